// ---- an_pkg.sv ----
`default_nettype none
package an_pkg;
   localparam int WORD_W = 16;
   localparam int SEL_W = 5;
   localparam int ABIL_LSB = 5;
   localparam int ABIL_W = 8;
   localparam int CODE_W = 11;
   localparam int USR_N = 4;
   localparam int USR_W = USR_N * CODE_W;
   localparam int OUI_W = 24;
   localparam int PHY_W = 32;
   localparam int MP_BIT = 13;
   localparam int NP_BIT = 15;
   localparam int CMD_BASE_BIT = 16;
   localparam logic [4:0] SEL_RSV_LO = 5'h00;
   localparam logic [4:0] SEL_ETH = 5'h01;
   localparam logic [4:0] SEL_ISOCH = 5'h02;
   localparam logic [4:0] SEL_RSV_HI = 5'h1F;
   localparam logic [7:0] ABIL_DEFINED = 8'h1F;
   localparam int A_10 = 0;
   localparam int A_10FD = 1;
   localparam int A_TX = 2;
   localparam int A_TXFD = 3;
   localparam int A_T4 = 4;
   typedef logic [CODE_W-1:0] ucode_t;
   localparam ucode_t MC_RSV_LO = 11'h000;
   localparam ucode_t MC_NULL = 11'h001;
   localparam ucode_t MC_TECH1 = 11'h002;
   localparam ucode_t MC_TECH2 = 11'h003;
   localparam ucode_t MC_FAULT = 11'h004;
   localparam ucode_t MC_OUI = 11'h005;
   localparam ucode_t MC_PHYID = 11'h006;
   localparam ucode_t MC_RSV_HI = 11'h7FF;
   localparam logic [1:0] FT_SELFTEST = 2'h0;
   localparam logic [1:0] FT_LINK_LOSS = 2'h1;
   localparam logic [1:0] FT_JABBER = 2'h2;
   localparam logic [1:0] FT_PARALLEL = 2'h3;
   // error flag positions
   localparam int E_SEL = 0;
   localparam int E_CODE = 1;
   localparam int E_ORPHAN = 2;
   localparam int E_REFUSED = 3;
   localparam int ERR_W = 4;
   typedef enum logic [2:0] {
      TECH_TXFD = 3'h0, TECH_T4 = 3'h1, TECH_TX = 3'h2, TECH_10FD = 3'h3,
      TECH_10 = 3'h4, TECH_VENDOR = 3'h5, TECH_NONE = 3'h7
   } tech_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} tx_st_t;

   function automatic logic [2:0] user_count(input ucode_t c);
      case (c)
         MC_TECH1, MC_FAULT: return 3'h1;
         MC_TECH2: return 3'h2;
         MC_OUI, MC_PHYID: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   function automatic logic legal_code(input ucode_t c);
      return (c >= MC_NULL) && (c <= MC_PHYID);
   endfunction

   function automatic logic [WORD_W-1:0] base_word(input logic [7:0] abil,
                                                   input logic np);
      logic [WORD_W-1:0] w;
      w = '0;
      w[SEL_W-1:0] = SEL_ETH;
      w[ABIL_LSB +: ABIL_W] = abil & ABIL_DEFINED;
      w[NP_BIT] = np;
      return w;
   endfunction

   // word i of a message: 0 is the message page, 1.. the user codes
   function automatic logic [WORD_W-1:0] msg_word(input ucode_t code,
      input logic [2:0] i, input logic [OUI_W-1:0] oui,
      input logic [PHY_W-1:0] phy, input logic [USR_W-1:0] usr,
      input logic np_more);
      logic [WORD_W-1:0] w;
      ucode_t u;
      int k;
      w = '0;
      k = 0;
      u = code;
      if (i != 3'h0) begin
         k = int'(i) - 1;
         u = usr[k*CODE_W +: CODE_W];
         if (code == MC_OUI) begin
            case (k)
               0: u = oui[23:13];
               1: u = oui[12:2];
               2: u = {oui[1:0], 9'h000};
               default: u = usr[3*CODE_W +: CODE_W];
            endcase
         end else if (code == MC_PHYID) begin
            case (k)
               0: u = phy[31:21];
               1: u = {phy[20:16], phy[15:10]};
               2: u = {phy[9:0], usr[2*CODE_W]};
               default: u = usr[3*CODE_W +: CODE_W];
            endcase
         end else if (code == MC_FAULT) begin
            u = {9'h000, usr[1:0]};
         end
      end
      w[CODE_W-1:0] = u;
      w[MP_BIT] = (i == 3'h0);
      w[NP_BIT] = (i < user_count(code)) ? 1'b1 : np_more;
      return w;
   endfunction

   function automatic tech_t resolve(input logic [7:0] common,
                                     input logic vendor,
                                     input logic [2:0] vrank);
      tech_t t;
      if (common[A_TXFD]) t = TECH_TXFD;
      else if (common[A_T4]) t = TECH_T4;
      else if (common[A_TX]) t = TECH_TX;
      else if (common[A_10FD]) t = TECH_10FD;
      else if (common[A_10]) t = TECH_10;
      else t = TECH_NONE;
      // vendor slots in above the standard ranks it outranks, order kept
      if (vendor && (3'(t) >= vrank)) t = TECH_VENDOR;
      return t;
   endfunction
endpackage
`default_nettype wire

// ---- an_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface an_link_if;
   logic [15:0] dev_word;
   logic dev_valid;
   logic [15:0] lp_word;
   logic lp_valid;
   modport dev (output dev_word, output dev_valid,
                input lp_word, input lp_valid);
   modport partner (input dev_word, input dev_valid,
                    output lp_word, output lp_valid);
endinterface
`default_nettype wire

// ---- an_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module an_partner (
   input wire logic clk,
   input wire logic rst_n,
   an_link_if.partner link,
   input wire logic base_go,
   input wire logic [7:0] base_abil,
   input wire logic msg_go,
   input wire logic [10:0] msg_code,
   input wire logic [43:0] msg_usr,
   input wire logic [23:0] oui,
   input wire logic [31:0] phy_id,
   input wire logic np_more,
   output logic busy,
   output logic refused,
   output logic [7:0] rx_abil,
   output logic [10:0] rx_code,
   output logic [43:0] rx_users,
   output logic [2:0] rx_err
);
   an_pkg::tx_st_t st_q;
   an_pkg::ucode_t code_q;
   logic base_q;
   logic [2:0] idx_q;
   logic [2:0] len_q;
   logic [7:0] abil_q;
   logic [43:0] usr_q;
   logic [23:0] oui_q;
   logic [31:0] phy_q;
   logic go;
   logic go_ok;
   logic rx_base_q;
   logic [2:0] need_q;
   logic [2:0] ridx_q;
   logic [15:0] w;

   assign go = base_go || msg_go;
   // reserved message codes never leave this end
   assign go_ok = (st_q == an_pkg::ST_IDLE) &&
      (base_go || an_pkg::legal_code(msg_code));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= an_pkg::ST_IDLE;
         code_q <= an_pkg::MC_NULL;
         base_q <= 1'b0;
         idx_q <= 3'h0;
         len_q <= 3'h1;
         abil_q <= 8'h00;
         usr_q <= '0;
         oui_q <= '0;
         phy_q <= '0;
      end else begin
         case (st_q)
            an_pkg::ST_IDLE: begin
               if (go && go_ok) begin
                  st_q <= an_pkg::ST_SEND;
                  base_q <= base_go;
                  code_q <= msg_code;
                  abil_q <= base_abil;
                  usr_q <= msg_usr;
                  oui_q <= oui;
                  phy_q <= phy_id;
                  idx_q <= 3'h0;
                  len_q <= base_go ? 3'h1 :
                     3'h1 + an_pkg::user_count(msg_code);
               end
            end
            an_pkg::ST_SEND: begin
               idx_q <= idx_q + 3'h1;
               if (idx_q == len_q - 3'h1) st_q <= an_pkg::ST_IDLE;
            end
            default: st_q <= an_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.lp_word <= 16'h0000;
         link.lp_valid <= 1'b0;
         busy <= 1'b0;
         refused <= 1'b0;
      end else begin
         link.lp_valid <= (st_q == an_pkg::ST_SEND);
         link.lp_word <= base_q ? an_pkg::base_word(abil_q, np_more) :
            an_pkg::msg_word(code_q, idx_q, oui_q, phy_q, usr_q,
                             np_more);
         busy <= (st_q == an_pkg::ST_SEND) || (go && go_ok);
         refused <= go && !go_ok;
      end
   end

   assign w = link.dev_word;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_base_q <= 1'b0;
         rx_abil <= 8'h00;
         rx_code <= an_pkg::MC_RSV_LO;
         rx_users <= '0;
         rx_err <= 3'h0;
         need_q <= 3'h0;
         ridx_q <= 3'h0;
      end else if (base_go) begin
         rx_base_q <= 1'b0;
         rx_err <= 3'h0;
         need_q <= 3'h0;
      end else if (link.dev_valid) begin
         if (!rx_base_q) begin
            if (w[an_pkg::SEL_W-1:0] == an_pkg::SEL_ETH) begin
               rx_base_q <= 1'b1;
               rx_abil <= w[an_pkg::ABIL_LSB +: an_pkg::ABIL_W];
            end else begin
               rx_err[an_pkg::E_SEL] <= 1'b1;
            end
         end else if (w[an_pkg::MP_BIT]) begin
            if (an_pkg::legal_code(w[an_pkg::CODE_W-1:0])) begin
               rx_code <= w[an_pkg::CODE_W-1:0];
               need_q <= an_pkg::user_count(w[an_pkg::CODE_W-1:0]);
               ridx_q <= 3'h0;
            end else begin
               rx_err[an_pkg::E_CODE] <= 1'b1;
               need_q <= 3'h0;
            end
         end else if (need_q != 3'h0) begin
            rx_users[ridx_q*an_pkg::CODE_W +: an_pkg::CODE_W] <=
               w[an_pkg::CODE_W-1:0];
            ridx_q <= ridx_q + 3'h1;
            need_q <= need_q - 3'h1;
         end else begin
            rx_err[an_pkg::E_ORPHAN] <= 1'b1;
         end
      end
   end
endmodule // an_partner
`default_nettype wire

// ---- an_device.sv ----
// Behaviour
// - five-bit message class field per code word
// - never send reserved class encodings
// - base page class value is 00001
// - abilities in bits D5..D12, A0 upward
// - A0..A4 map to the five standard technologies
// - reserved abilities A5..A7 sent as zero
// - pick highest common technology, fixed order
// - vendor technology ranks anywhere, standard order kept
// - message page precedes every unformatted run
// - message code eleven bits, undefined values reserved
// - never send message codes 0 or 2047
// - send null message when nothing left
// - codes 2 and 3 announce ability user codes
// - code 4 carries one fault type user code
// - fault type 3 reports parallel detection fault
// - organization tag: code five, four user codes
// - organization identifier split over three user codes
// - transceiver tag: code six, four user codes
// - transceiver identifier split over three user codes
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module an_device #(
   parameter int ADDR_W = 8,
   parameter logic [2:0] VENDOR_RANK = 3'h5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic pdf_status,
   an_link_if.dev link
);
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LOC_ABIL = 8'h04;
   localparam logic [ADDR_W-1:0] REG_CMD = 8'h08;
   localparam logic [ADDR_W-1:0] REG_TXU0 = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_TXU1 = 8'h10;
   localparam logic [ADDR_W-1:0] REG_TXU2 = 8'h14;
   localparam logic [ADDR_W-1:0] REG_TXU3 = 8'h18;
   localparam logic [ADDR_W-1:0] REG_OUI = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_PHYID = 8'h20;
   localparam logic [ADDR_W-1:0] REG_LP_ABIL = 8'h30;
   localparam logic [ADDR_W-1:0] REG_RESULT = 8'h34;
   localparam logic [ADDR_W-1:0] REG_RXMSG = 8'h38;
   localparam logic [ADDR_W-1:0] REG_RXU01 = 8'h3C;
   localparam logic [ADDR_W-1:0] REG_RXU23 = 8'h40;
   localparam logic [ADDR_W-1:0] REG_ERR = 8'h44;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h48;
   localparam int C_NP = 0;
   localparam int C_NULL_EN = 1;
   localparam int C_RESTART = 2;
   localparam int C_VENDOR = 3;
   localparam int C_PDF_EN = 4;
   localparam logic [4:0] CTRL_RESET = 5'h02;
   localparam logic [7:0] ABIL_RESET = 8'h1F;

   logic [4:0] ctrl_q;
   logic [7:0] loc_abil_q;
   logic [43:0] usr_q;
   logic [23:0] oui_q;
   logic [31:0] phy_q;
   an_pkg::tx_st_t st_q;
   an_pkg::ucode_t code_q;
   logic base_q;
   logic [2:0] idx_q;
   logic [2:0] len_q;
   logic rx_base_q;
   logic [7:0] lp_abil_q;
   an_pkg::ucode_t rx_code_q;
   logic [2:0] need_q;
   logic [2:0] ridx_q;
   logic [43:0] rx_usr_q;
   logic [3:0] err_q;
   logic [3:0] err_set;
   an_pkg::tech_t result_q;
   logic cmd_wr;
   logic cmd_base;
   an_pkg::ucode_t cmd_code;
   logic cmd_ok;
   logic restart;
   logic auto_null;
   logic [43:0] usr_eff;
   logic [15:0] w;
   an_pkg::ucode_t w_code;

   assign cmd_wr = wr && (addr == REG_CMD);
   assign cmd_base = wdata[an_pkg::CMD_BASE_BIT];
   assign cmd_code = wdata[an_pkg::CODE_W-1:0];
   // a refused command leaves the link untouched; software sees the flag
   assign cmd_ok = cmd_wr && (st_q == an_pkg::ST_IDLE) &&
      (cmd_base || an_pkg::legal_code(cmd_code));
   assign restart = wr && (addr == REG_CTRL) && wdata[C_RESTART];
   // answer a partner next page with a null page when idle and nothing is queued
   assign auto_null = ctrl_q[C_NULL_EN] && link.lp_valid && rx_base_q &&
      (st_q == an_pkg::ST_IDLE) && !cmd_wr;
   // fault type follows the parallel detection status while enabled
   assign usr_eff = (ctrl_q[C_PDF_EN] && pdf_status) ?
      {usr_q[43:2], an_pkg::FT_PARALLEL} : usr_q;
   assign w = link.lp_word;
   assign w_code = w[an_pkg::CODE_W-1:0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
         loc_abil_q <= ABIL_RESET;
         usr_q <= '0;
         oui_q <= '0;
         phy_q <= '0;
      end else if (wr) begin
         if (addr == REG_CTRL) begin
            ctrl_q <= wdata[4:0];
            ctrl_q[C_RESTART] <= 1'b0;
         end else if (addr == REG_LOC_ABIL) begin
            loc_abil_q <= wdata[7:0];
         end else if (addr == REG_TXU0) begin
            usr_q[10:0] <= wdata[10:0];
         end else if (addr == REG_TXU1) begin
            usr_q[21:11] <= wdata[10:0];
         end else if (addr == REG_TXU2) begin
            usr_q[32:22] <= wdata[10:0];
         end else if (addr == REG_TXU3) begin
            usr_q[43:33] <= wdata[10:0];
         end else if (addr == REG_OUI) begin
            oui_q <= wdata[23:0];
         end else if (addr == REG_PHYID) begin
            phy_q <= wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= an_pkg::ST_IDLE;
         code_q <= an_pkg::MC_NULL;
         base_q <= 1'b0;
         idx_q <= 3'h0;
         len_q <= 3'h1;
      end else begin
         case (st_q)
            an_pkg::ST_IDLE: begin
               if (cmd_ok) begin
                  st_q <= an_pkg::ST_SEND;
                  base_q <= cmd_base;
                  code_q <= cmd_code;
                  idx_q <= 3'h0;
                  len_q <= cmd_base ? 3'h1 :
                     3'h1 + an_pkg::user_count(cmd_code);
               end else if (auto_null) begin
                  st_q <= an_pkg::ST_SEND;
                  base_q <= 1'b0;
                  code_q <= an_pkg::MC_NULL;
                  idx_q <= 3'h0;
                  len_q <= 3'h1;
               end
            end
            an_pkg::ST_SEND: begin
               idx_q <= idx_q + 3'h1;
               if (idx_q == len_q - 3'h1) st_q <= an_pkg::ST_IDLE;
            end
            default: st_q <= an_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.dev_word <= 16'h0000;
         link.dev_valid <= 1'b0;
      end else begin
         link.dev_valid <= (st_q == an_pkg::ST_SEND);
         link.dev_word <= base_q ?
            an_pkg::base_word(loc_abil_q, ctrl_q[C_NP]) :
            an_pkg::msg_word(code_q, idx_q, oui_q, phy_q, usr_eff,
                             ctrl_q[C_NP]);
      end
   end

   always_comb begin
      err_set = 4'h0;
      err_set[an_pkg::E_REFUSED] = cmd_wr && !cmd_ok;
      if (link.lp_valid) begin
         if (!rx_base_q) begin
            err_set[an_pkg::E_SEL] = (w[an_pkg::SEL_W-1:0] !=
                                      an_pkg::SEL_ETH);
         end else if (w[an_pkg::MP_BIT]) begin
            err_set[an_pkg::E_CODE] = !an_pkg::legal_code(w_code);
         end else begin
            err_set[an_pkg::E_ORPHAN] = (need_q == 3'h0);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_base_q <= 1'b0;
         lp_abil_q <= 8'h00;
         rx_code_q <= an_pkg::MC_RSV_LO;
         need_q <= 3'h0;
         ridx_q <= 3'h0;
         rx_usr_q <= '0;
      end else if (restart) begin
         rx_base_q <= 1'b0;
         need_q <= 3'h0;
      end else if (link.lp_valid) begin
         if (!rx_base_q) begin
            if (!err_set[an_pkg::E_SEL]) begin
               rx_base_q <= 1'b1;
               lp_abil_q <= w[an_pkg::ABIL_LSB +: an_pkg::ABIL_W];
            end
         end else if (w[an_pkg::MP_BIT]) begin
            need_q <= err_set[an_pkg::E_CODE] ? 3'h0 :
               an_pkg::user_count(w_code);
            ridx_q <= 3'h0;
            if (!err_set[an_pkg::E_CODE]) rx_code_q <= w_code;
         end else if (need_q != 3'h0) begin
            rx_usr_q[ridx_q*an_pkg::CODE_W +: an_pkg::CODE_W] <= w_code;
            ridx_q <= ridx_q + 3'h1;
            need_q <= need_q - 3'h1;
         end
      end
   end

   // write-one-to-clear; a new event in the same cycle keeps its flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 4'h0;
      end else begin
         err_q <= (err_q & ~((wr && addr == REG_ERR) ? wdata[3:0] : 4'h0))
                  | err_set;
      end
   end

   // result is held at none until a partner base page has arrived
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= an_pkg::TECH_NONE;
      end else begin
         result_q <= rx_base_q ?
            an_pkg::resolve(loc_abil_q & lp_abil_q & an_pkg::ABIL_DEFINED,
                            ctrl_q[C_VENDOR], VENDOR_RANK) :
            an_pkg::TECH_NONE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         if (addr == REG_CTRL) rdata <= {27'h0, ctrl_q};
         else if (addr == REG_LOC_ABIL) rdata <= {24'h0, loc_abil_q};
         else if (addr == REG_TXU0) rdata <= {21'h0, usr_q[10:0]};
         else if (addr == REG_TXU1) rdata <= {21'h0, usr_q[21:11]};
         else if (addr == REG_TXU2) rdata <= {21'h0, usr_q[32:22]};
         else if (addr == REG_TXU3) rdata <= {21'h0, usr_q[43:33]};
         else if (addr == REG_OUI) rdata <= {8'h0, oui_q};
         else if (addr == REG_PHYID) rdata <= phy_q;
         else if (addr == REG_LP_ABIL) rdata <= {24'h0, lp_abil_q};
         else if (addr == REG_RESULT) rdata <= {29'h0, result_q};
         else if (addr == REG_RXMSG) rdata <= {18'h0, need_q, rx_code_q};
         else if (addr == REG_RXU01) rdata <= {5'h0, rx_usr_q[21:11],
                                               5'h0, rx_usr_q[10:0]};
         else if (addr == REG_RXU23) rdata <= {5'h0, rx_usr_q[43:33],
                                               5'h0, rx_usr_q[32:22]};
         else if (addr == REG_ERR) rdata <= {28'h0, err_q};
         else if (addr == REG_STATUS) rdata <= {30'h0, rx_base_q,
                                                st_q == an_pkg::ST_SEND};
         else rdata <= 32'h00000000;
      end else begin
         rdata <= 32'h00000000;
      end
   end
endmodule // an_device
`default_nettype wire

// ---- an_pkg_fix_note_unused.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- an_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module an_link_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] dev_word,
   input wire logic dev_valid,
   input wire logic [15:0] lp_word,
   input wire logic lp_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire dmp = dev_valid && dev_word[13];
   wire lmp = lp_valid && lp_word[13];
   chk_dev_code_ok: assert property (
      dmp |-> dev_word[10:0] inside {[11'h001:11'h006]})
      else $error("device sent a reserved message code");
   chk_lp_code_ok: assert property (
      lmp |-> lp_word[10:0] inside {[11'h001:11'h006]})
      else $error("partner sent a reserved message code");
   // user codes follow back to back, so a word after a gap is a base page
   chk_dev_base_form: assert property (
      dev_valid && !dev_word[13] && !$past(dev_valid)
      |-> dev_word[4:0] == 5'h01 && dev_word[12:10] == 3'h0)
      else $error("device base page badly formed");
   chk_lp_base_form: assert property (
      lp_valid && !lp_word[13] && !$past(lp_valid)
      |-> lp_word[4:0] == 5'h01 && lp_word[12:10] == 3'h0)
      else $error("partner base page badly formed");
   chk_dev_tag_len: assert property (
      dmp && dev_word[10:0] inside {11'h005, 11'h006}
      |=> (dev_valid && !dev_word[13] && dev_word[15])[*3]
      ##1 (dev_valid && !dev_word[13]) ##1 !dev_valid)
      else $error("device tag message not four user codes");
   chk_lp_tag_len: assert property (
      lmp && lp_word[10:0] inside {11'h005, 11'h006}
      |=> (lp_valid && !lp_word[13])[*4] ##1 !lp_valid)
      else $error("partner tag message not four user codes");
   chk_dev_fault_len: assert property (
      dmp && dev_word[10:0] == 11'h004 |=> dev_valid && !dev_word[13]
      && dev_word[10:2] == 9'h000 ##1 !dev_valid)
      else $error("device fault message malformed");
   chk_dev_tech_two: assert property (
      dmp && dev_word[10:0] == 11'h003
      |=> (dev_valid && !dev_word[13])[*2] ##1 !dev_valid)
      else $error("device ability extension length wrong");
   chk_dev_null_one: assert property (
      dmp && dev_word[10:0] == 11'h001 |=> !dev_valid)
      else $error("device null message not single");
   chk_dev_np_chain: assert property (
      dmp && dev_word[10:0] != 11'h001 |-> dev_word[15])
      else $error("device message page lacks next page flag");
   cov_dev_tag: cover property (dmp && dev_word[10:0] == 11'h006);
   cov_dev_null: cover property (dmp && dev_word[10:0] == 11'h001);
   cov_lp_msg: cover property (lmp);
endmodule // an_link_sva
`default_nettype wire

// ---- autoneg_page_content_logic_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module autoneg_page_content_logic_test;
   localparam logic [23:0] OUI_V = 24'hA5C3E1;
   localparam logic [31:0] PHY_V = 32'h1234ABCD;
   localparam logic [23:0] OUI_P = 24'h3C5A96;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pdf_status = 1'b0;
   logic base_go = 1'b0;
   logic msg_go = 1'b0;
   logic [7:0] base_abil = 8'h00;
   logic [10:0] msg_code = 11'h000;
   logic [43:0] msg_usr = 44'h0;
   logic [31:0] rdata;
   logic busy, refused, saw_ref = 1'b0;
   logic [7:0] rx_abil;
   logic [10:0] rx_code;
   logic [43:0] rx_users;
   logic [2:0] rx_err;
   logic [10:0] txu [4] = '{11'h5A1, 11'h2B3, 11'h4C6, 11'h3D7};
   logic [7:0] ab [8] = '{8'h1F, 8'h16, 8'h05, 8'h03, 8'h01, 8'h00,
                          8'h00, 8'h01};
   int res [8] = '{0, 1, 2, 3, 4, 7, 5, 4};
   int nu [7] = '{0, 0, 1, 2, 1, 4, 4};
   int rz [4] = '{0, 7, 2047, 6};
   int bad_count = 0;
   int comparisons = 0;
   an_link_if u_an_link_if ();
   an_device u_an_device (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
      .pdf_status, .link(u_an_link_if.dev));
   an_partner u_an_partner (.clk, .rst_n, .link(u_an_link_if.partner),
      .base_go, .base_abil, .msg_go, .msg_code, .msg_usr,
      .oui(OUI_P), .phy_id(PHY_V), .np_more(1'b0), .busy, .refused,
      .rx_abil, .rx_code, .rx_users, .rx_err);
   an_link_sva u_an_link_sva (.clk, .rst_n,
      .dev_word(u_an_link_if.dev_word), .dev_valid(u_an_link_if.dev_valid),
      .lp_word(u_an_link_if.lp_word), .lp_valid(u_an_link_if.lp_valid));
   initial forever #20 clk = ~clk;
   // refused lasts one cycle, so it is latched rather than polled
   always @(posedge clk) if (refused === 1'b1) saw_ref <= 1'b1;
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b0;
         base_go <= 1'b0;
         msg_go <= 1'b0;
      end
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata & m, e);
   endtask
   task automatic pgo(input logic b, input logic [7:0] ba,
                      input logic [10:0] c, input logic [43:0] u);
      @(posedge clk);
      wr <= 1'b0;
      base_go <= b;
      msg_go <= !b;
      base_abil <= ba;
      msg_code <= c;
      msg_usr <= u;
      cyc(1);
      repeat (20) if (busy === 1'b1) cyc(1);
      if (busy !== 1'b0) begin
         bad_count++;
         close_out();
      end
      cyc(4);
   endtask
   function automatic logic [10:0] exp_u(input int c, input int k);
      case (c)
         4: return {9'h000, txu[0][1:0]};
         5: return k == 0 ? OUI_V[23:13] : k == 1 ? OUI_V[12:2] :
                   k == 2 ? {OUI_V[1:0], 9'h000} : txu[3];
         6: return k == 0 ? PHY_V[31:21] : k == 1 ? PHY_V[20:10] :
                   k == 2 ? {PHY_V[9:0], txu[2][0]} : txu[3];
         default: return txu[k];
      endcase
   endfunction
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(8'h00, 32'hFF, 32'h02);
      rd_chk(8'h04, 32'hFF, 32'h1F);
      rd_chk(8'h34, 32'h7, 32'h7);
      rd_chk(8'h2C, 32'hFFFFFFFF, 32'h0);
      wr_reg(8'h04, 32'hFF);
      rd_chk(8'h04, 32'hFF, 32'hFF);
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h00, i > 5 ? 32'hE : 32'h6);
         pgo(1'b1, ab[i], 11'h000, 44'h0);
         rd_chk(8'h30, 32'hFF, {24'h0, ab[i]});
         rd_chk(8'h34, 32'h7, res[i]);
      end
      wr_reg(8'h08, 32'h10000);
      rd_chk(8'h48, 32'h3, 32'h3);
      cyc(6);
      check({24'h0, rx_abil}, 32'h1F);
      for (int k = 0; k < 4; k++) wr_reg(8'h0C + 8'(4 * k), {21'h0, txu[k]});
      wr_reg(8'h1C, {8'h0, OUI_V});
      wr_reg(8'h20, PHY_V);
      for (int c = 2; c < 7; c++) begin
         wr_reg(8'h08, 32'(c));
         cyc(8);
         check({21'h0, rx_code}, 32'(c));
         for (int k = 0; k < nu[c]; k++)
            check({21'h0, rx_users[11*k +: 11]}, {21'h0, exp_u(c, k)});
      end
      wr_reg(8'h00, 32'h12);
      pdf_status <= 1'b1;
      wr_reg(8'h08, 32'h4);
      cyc(8);
      check({21'h0, rx_users[10:0]}, 32'h3);
      for (int j = 0; j < 4; j++) begin
         wr_reg(8'h08, 32'(rz[j]));
         if (j == 3) wr_reg(8'h08, 32'h1);
         cyc(8);
         rd_chk(8'h44, 32'hF, 32'h8);
         wr_reg(8'h44, 32'h8);
         rd_chk(8'h44, 32'hF, 32'h0);
      end
      check({21'h0, rx_code}, 32'h6);
      check({29'h0, rx_err}, 32'h0);
      pgo(1'b0, 8'h00, 11'h006, {11'h2A5, 10'h0, 1'b1, 22'h0});
      rd_chk(8'h38, 32'h7FF, 32'h6);
      rd_chk(8'h3C, 32'hFFFFFFFF, {5'h0, PHY_V[20:10], 5'h0, PHY_V[31:21]});
      rd_chk(8'h40, 32'hFFFFFFFF, {5'h0, 11'h2A5, 5'h0, PHY_V[9:0], 1'b1});
      check({21'h0, rx_code}, 32'h1);
      pgo(1'b0, 8'h00, 11'h005, {11'h1C3, 33'h0});
      rd_chk(8'h3C, 32'hFFFFFFFF,
             {5'h0, OUI_P[12:2], 5'h0, OUI_P[23:13]});
      rd_chk(8'h40, 32'hFFFFFFFF,
             {5'h0, 11'h1C3, 5'h0, OUI_P[1:0], 9'h000});
      // after a restart a message page arrives where a base page belongs
      wr_reg(8'h00, 32'h6);
      pgo(1'b0, 8'h00, 11'h004, 44'h0);
      rd_chk(8'h44, 32'hF, 32'h1);
      rd_chk(8'h34, 32'h7, 32'h7);
      pgo(1'b0, 8'h00, 11'h000, 44'h0);
      check({31'h0, saw_ref}, 32'h1);
      close_out();
   end
endmodule // autoneg_page_content_logic_test
`default_nettype wire
